// ==== core/isb_core.sv ====
// Strobed register access was decided locally.
`timescale 1ns/10ps
module isb_core (
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_sys_rst,
  // Register port
  input wire isb_pkg::isb_bus_s i_bus,
  output logic [15:0] o_rdata,
  // Bus pins and shift engine
  input wire isb_pkg::isb_pins_s i_pins,
  input wire isb_pkg::isb_eng_s i_eng,
  output logic [7:0] o_tx_byte,
  output logic o_tx_full,
  output logic o_auto_stop,
  output logic o_soft_reset_hold,
  output logic [1:0] o_auto_stop_select,
  // Interrupt
  output logic o_irq
);
  import isb_pkg::*;

  typedef struct packed {
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    logic bus_busy_flag;
    logic general_call_seen;
    logic [7:0] transfer_byte_count;
    logic [3:0] bit_cnt;
    logic [7:0] byte_count_limit;
    logic [1:0] auto_stop_select;
    logic soft_reset_hold;
    logic [7:0] received_byte;
    logic [7:0] outgoing_byte;
    logic tx_full;
    logic addr_done;
    logic [ISB_IRQ_W-1:0] irq_stat;
    logic [ISB_IRQ_W-1:0] irq_mask;
    logic [15:0] rdata;
  } isb_state_s;

  isb_state_s st;
  isb_state_s next_st;

  function automatic logic hit(input isb_bus_s b, input logic [15:0] ofs);
    hit = b.addr == ofs;
  endfunction

  logic start_det;
  logic stop_det;
  logic scl_rise;
  logic count_hit;
  logic [ISB_IRQ_W-1:0] irq_set;
  logic [ISB_IRQ_W-1:0] irq_clr;

  // ****************************************
  // Line conditions
  // ****************************************
  // Edges come from the second sync stage and its delayed copy only
  assign start_det = st.scl_q && st.scl_sync[1] && st.sda_q && !st.sda_sync[1];
  assign stop_det = st.scl_q && st.scl_sync[1] && !st.sda_q && st.sda_sync[1];
  assign scl_rise = !st.scl_q && st.scl_sync[1];
  // only non-zero selections compare the threshold
  // The address byte never counts, or a threshold of one would fire before any data
  assign count_hit = (st.auto_stop_select != ISB_ASTP_NONE) && (st.bit_cnt == 4'(ISB_BITS_PER_BYTE - 1))
    && scl_rise && st.bus_busy_flag && st.addr_done && !st.soft_reset_hold
    && (8'(st.transfer_byte_count + 8'h01) == st.byte_count_limit);

  always_comb begin
    irq_set = '0;
    irq_clr = '0;
    irq_set[ISB_IRQ_RX] = i_eng.rx_done;
    irq_set[ISB_IRQ_TX] = i_eng.tx_load;
    irq_set[ISB_IRQ_STOP] = stop_det;
    irq_set[ISB_IRQ_CNT] = count_hit;
    if (i_bus.wr && hit(i_bus, ISB_OFS_IRQ_STAT)) begin
      irq_clr = i_bus.wdata[ISB_IRQ_W-1:0];
    end
    if (i_bus.rd && hit(i_bus, ISB_OFS_RXBUF)) begin
      irq_clr[ISB_IRQ_RX] = 1'b1;
    end
    if (i_bus.wr && hit(i_bus, ISB_OFS_TXBUF)) begin
      irq_clr[ISB_IRQ_TX] = 1'b1;
    end
  end

  always_comb begin
    next_st = st;
    next_st.scl_sync = {st.scl_sync[0], i_pins.scl};
    next_st.sda_sync = {st.sda_sync[0], i_pins.sda};
    next_st.scl_q = st.scl_sync[1];
    next_st.sda_q = st.sda_sync[1];
    // ****************************************
    // Bus state and byte counter
    // ****************************************
    if (start_det) begin
      next_st.bus_busy_flag = 1'b1;
    end else if (stop_det) begin
      next_st.bus_busy_flag = 1'b0;
    end
    if (start_det) begin
      next_st.general_call_seen = 1'b0;
    end else if (i_eng.gc_match) begin
      next_st.general_call_seen = 1'b1;
    end
    // Counter runs free of the register port; a read mid-bit may see a stale value
    if (start_det) begin
      next_st.transfer_byte_count = ISB_RST_BYTE;
      next_st.bit_cnt = '0;
    end else if (st.bus_busy_flag && scl_rise) begin
      if (st.bit_cnt == 4'(ISB_BITS_PER_BYTE - 1)) begin
        next_st.bit_cnt = '0;
        next_st.transfer_byte_count = 8'(st.transfer_byte_count + 8'h01);
      end else begin
        next_st.bit_cnt = 4'(st.bit_cnt + 4'h1);
      end
    end
    // Skip the address byte: count only after the first byte of a frame
    if (st.bus_busy_flag && scl_rise && st.bit_cnt == 4'(ISB_BITS_PER_BYTE - 1)
        && st.transfer_byte_count == ISB_RST_BYTE && !st.addr_done) begin
      next_st.transfer_byte_count = st.transfer_byte_count;
      next_st.addr_done = 1'b1;
    end
    // Every START or STOP opens a new address phase
    if (start_det || stop_det) begin
      next_st.addr_done = 1'b0;
    end
    // ****************************************
    // Data buffers
    // ****************************************
    if (i_eng.rx_done) begin
      next_st.received_byte = i_eng.rx_byte;
    end
    if (i_eng.tx_load) begin
      next_st.tx_full = 1'b0;
    end
    if (i_bus.wr && hit(i_bus, ISB_OFS_TXBUF)) begin
      next_st.outgoing_byte = i_bus.wdata[7:0];
      next_st.tx_full = 1'b1;
    end
    // ****************************************
    // Control registers
    // ****************************************
    if (i_bus.wr && hit(i_bus, ISB_OFS_CTRL)) begin
      next_st.soft_reset_hold = i_bus.wdata[ISB_BIT_SWRST];
      if (st.soft_reset_hold) begin
        next_st.auto_stop_select = i_bus.wdata[ISB_POS_ASTP +: 2];
      end
    end
    if (i_bus.wr && hit(i_bus, ISB_OFS_LIMIT) && st.soft_reset_hold) begin
      next_st.byte_count_limit = i_bus.wdata[7:0];
    end
    if (i_bus.wr && hit(i_bus, ISB_OFS_IRQ_MASK)) begin
      next_st.irq_mask = i_bus.wdata[ISB_IRQ_W-1:0];
    end
    // Set wins over a clear in the same cycle
    next_st.irq_stat = (st.irq_stat & ~irq_clr) | irq_set;
    // ****************************************
    // Read data, one cycle after the strobe
    // ****************************************
    next_st.rdata = ISB_RST_WORD;
    if (i_bus.rd) begin
      case (i_bus.addr)
        ISB_OFS_STATUS: begin
          next_st.rdata = {st.transfer_byte_count, 1'b0, i_eng.scl_hold, st.general_call_seen,
            st.bus_busy_flag, 4'h0};
        end
        ISB_OFS_LIMIT: begin
          next_st.rdata = {8'h00, st.byte_count_limit};
        end
        ISB_OFS_RXBUF: begin
          next_st.rdata = {8'h00, st.received_byte};
        end
        ISB_OFS_TXBUF: begin
          next_st.rdata = {8'h00, st.outgoing_byte};
        end
        ISB_OFS_CTRL: begin
          next_st.rdata = {13'h0000, st.auto_stop_select, st.soft_reset_hold};
        end
        ISB_OFS_IRQ_STAT: begin
          next_st.rdata = {12'h000, st.irq_stat};
        end
        ISB_OFS_IRQ_MASK: begin
          next_st.rdata = {12'h000, st.irq_mask};
        end
        default: begin
          next_st.rdata = ISB_RST_WORD;
        end
      endcase
    end
    // Soft reset clears the byte and bit counters, general call and tx_full but keeps configuration; busy still follows START and STOP
    if (st.soft_reset_hold) begin
      next_st.transfer_byte_count = ISB_RST_BYTE;
      next_st.bit_cnt = '0;
      next_st.general_call_seen = 1'b0;
      next_st.tx_full = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      st <= '0;
      st.scl_sync <= 2'h3;
      st.sda_sync <= 2'h3;
      st.scl_q <= 1'b1;
      st.sda_q <= 1'b1;
      st.soft_reset_hold <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  assign o_rdata = st.rdata;
  assign o_tx_byte = st.outgoing_byte;
  assign o_tx_full = st.tx_full;
  assign o_soft_reset_hold = st.soft_reset_hold;
  assign o_auto_stop_select = st.auto_stop_select;
  assign o_auto_stop = count_hit && (st.auto_stop_select == ISB_ASTP_STOP);
  assign o_irq = |(st.irq_stat & st.irq_mask);

  // ****************************************
  // Checks
  // ****************************************
  AST_BUSY_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    start_det |=> st.bus_busy_flag)
    else $error("busy not set after start");
  AST_BUSY_CLR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    stop_det && !start_det |=> !st.bus_busy_flag)
    else $error("busy not cleared after stop");
  AST_BUSY_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !start_det && !stop_det |=> $stable(st.bus_busy_flag))
    else $error("busy changed without a line condition");
  AST_GC_CLR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    start_det |=> !st.general_call_seen)
    else $error("general call kept over start");
  AST_GC_SET: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_eng.gc_match && !start_det && !st.soft_reset_hold |=> st.general_call_seen)
    else $error("general call not recorded");

  // ****************************************
  // Status word read-back
  // ****************************************
  // Read data belong to the state of the strobe cycle, so compare against the past value
  AST_RD_BUSY: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.rd && hit(i_bus, ISB_OFS_STATUS) |=> o_rdata[ISB_BIT_BUSY] == $past(st.bus_busy_flag))
    else $error("busy bit misread");
  AST_RD_SCL_LOW: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.rd && hit(i_bus, ISB_OFS_STATUS) |=> o_rdata[ISB_BIT_SCL_LOW] == $past(i_eng.scl_hold))
    else $error("clock low bit misread");
  AST_RD_GC: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.rd && hit(i_bus, ISB_OFS_STATUS) |=> o_rdata[ISB_BIT_GC] == $past(st.general_call_seen))
    else $error("general call bit misread");
  AST_RD_CNT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.rd && hit(i_bus, ISB_OFS_STATUS) |=> o_rdata[15:8] == $past(st.transfer_byte_count))
    else $error("byte count misread");
  AST_RD_IDLE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !i_bus.rd |=> o_rdata == ISB_RST_WORD)
    else $error("read data outside the answer cycle");

  // ****************************************
  // Byte counter and threshold
  // ****************************************
  AST_CNT_ZERO: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    start_det |=> st.transfer_byte_count == 8'h00)
    else $error("count not restarted");
  AST_CNT_STEP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !start_det && !st.soft_reset_hold && st.bus_busy_flag && scl_rise && st.addr_done
    && st.bit_cnt == 4'(ISB_BITS_PER_BYTE - 1) |=> st.transfer_byte_count == 8'($past(st.transfer_byte_count) + 8'h01))
    else $error("count missed a data byte");
  AST_CNT_ADDR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !start_det && !st.soft_reset_hold && st.bus_busy_flag && scl_rise && !st.addr_done
    && st.bit_cnt == 4'(ISB_BITS_PER_BYTE - 1) |=> st.transfer_byte_count == 8'h00 && st.addr_done)
    else $error("address byte counted");
  AST_LIMIT_LOCK: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    !st.soft_reset_hold |=> $stable(st.byte_count_limit))
    else $error("limit changed out of reset");
  AST_LIMIT_WR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.wr && hit(i_bus, ISB_OFS_LIMIT) && st.soft_reset_hold |=> st.byte_count_limit == $past(i_bus.wdata[7:0]))
    else $error("limit write lost in reset");
  AST_HIT_LIMIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    count_hit |-> 8'(st.transfer_byte_count + 8'h01) == st.byte_count_limit)
    else $error("count flag off the threshold");
  AST_NO_CNT_NONE: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st.auto_stop_select == ISB_ASTP_NONE |-> !count_hit)
    else $error("count flag with selection 00");
  AST_CNT_FLAG: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    count_hit |=> st.irq_stat[ISB_IRQ_CNT])
    else $error("count flag not raised");
  AST_STOP_ONLY_10: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    o_auto_stop |-> st.auto_stop_select == ISB_ASTP_STOP && count_hit)
    else $error("stray auto stop");
  AST_STOP_AT_HIT: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    count_hit && st.auto_stop_select == ISB_ASTP_STOP |-> o_auto_stop)
    else $error("auto stop missing at threshold");
  AST_FLAG_NO_STOP: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st.auto_stop_select == ISB_ASTP_FLAG |-> !o_auto_stop)
    else $error("auto stop with flag-only selection");

  // ****************************************
  // Data buffers
  // ****************************************
  AST_RX_CLR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.rd && hit(i_bus, ISB_OFS_RXBUF) && !i_eng.rx_done |=> !st.irq_stat[ISB_IRQ_RX])
    else $error("rx flag not cleared by read");
  AST_RX_IRQ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_eng.rx_done |=> st.irq_stat[ISB_IRQ_RX])
    else $error("rx flag not set");
  AST_TX_CLR: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.wr && hit(i_bus, ISB_OFS_TXBUF) && !i_eng.tx_load |=> !st.irq_stat[ISB_IRQ_TX])
    else $error("tx flag not cleared by write");
  AST_RX_DATA: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_eng.rx_done |=> st.received_byte == $past(i_eng.rx_byte))
    else $error("rx byte lost");
  AST_RX_READ: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.rd && hit(i_bus, ISB_OFS_RXBUF) |=> o_rdata == {8'h00, $past(st.received_byte)})
    else $error("rx buffer misread");
  AST_TX_HOLD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    st.tx_full && !i_eng.tx_load && !i_bus.wr |=> $stable(st.outgoing_byte))
    else $error("tx byte moved");
  AST_TX_FULL: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_bus.wr && hit(i_bus, ISB_OFS_TXBUF) && !st.soft_reset_hold |=> st.tx_full
    && st.outgoing_byte == $past(i_bus.wdata[7:0]))
    else $error("tx byte not taken");
  AST_TX_LOAD: assert property (@(posedge i_clk) disable iff (i_sys_rst)
    i_eng.tx_load && !(i_bus.wr && hit(i_bus, ISB_OFS_TXBUF)) |=> !st.tx_full)
    else $error("tx buffer still full after load");
  COV_FRAME: cover property (@(posedge i_clk) start_det ##[1:1000] stop_det);
  COV_COUNT: cover property (@(posedge i_clk) count_hit);
  COV_FLAG: cover property (@(posedge i_clk) count_hit && st.auto_stop_select == ISB_ASTP_FLAG);
  COV_AUTOSTOP: cover property (@(posedge i_clk) o_auto_stop);
  COV_IRQ: cover property (@(posedge i_clk) o_irq);

endmodule

// ==== core/isb_pkg.sv ====
package isb_pkg;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [15:0] ISB_OFS_STATUS = 16'h01C8;
  localparam logic [15:0] ISB_OFS_LIMIT = 16'h01CA;
  localparam logic [15:0] ISB_OFS_RXBUF = 16'h01CC;
  localparam logic [15:0] ISB_OFS_TXBUF = 16'h01CE;
  localparam logic [15:0] ISB_OFS_CTRL = 16'h01D0;
  localparam logic [15:0] ISB_OFS_IRQ_STAT = 16'h01D2;
  localparam logic [15:0] ISB_OFS_IRQ_MASK = 16'h01D4;

  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int ISB_BIT_SCL_LOW = 6;
  localparam int ISB_BIT_GC = 5;
  localparam int ISB_BIT_BUSY = 4;
  localparam int ISB_BIT_SWRST = 0;
  localparam int ISB_POS_ASTP = 1;
  localparam logic [15:0] ISB_RST_WORD = 16'h0000;
  localparam logic [7:0] ISB_RST_BYTE = 8'h00;
  localparam logic [1:0] ISB_ASTP_NONE = 2'h0;
  localparam logic [1:0] ISB_ASTP_FLAG = 2'h1;
  localparam logic [1:0] ISB_ASTP_STOP = 2'h2;
  localparam int ISB_BITS_PER_BYTE = 9;

  // Interrupt status bit positions
  localparam int ISB_IRQ_RX = 0;
  localparam int ISB_IRQ_TX = 1;
  localparam int ISB_IRQ_STOP = 2;
  localparam int ISB_IRQ_CNT = 3;
  localparam int ISB_IRQ_W = 4;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } isb_bus_s;

  typedef struct packed {
    logic scl;
    logic sda;
  } isb_pins_s;

  // Events from the shift engine, same clock as this block
  typedef struct packed {
    logic rx_done;
    logic [7:0] rx_byte;
    logic tx_load;
    logic gc_match;
    logic scl_hold;
  } isb_eng_s;

endpackage

// ==== verification/isb_i2c_model.sv ====
`timescale 1ns/10ps
module isb_i2c_model (
  // Bus lines, pulled high while released
  output logic o_scl,
  output logic o_sda
);
  initial begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  // SCL stands still between calls, as a real master leaves it
  task automatic start();
    o_sda = 1'b1;
    #12;
    o_scl = 1'b1;
    #24;
    o_sda = 1'b0;
    #24;
    o_scl = 1'b0;
    #12;
  endtask
  // Eight data bits and the acknowledge slot, 48 ns per bit
  task automatic send_byte(input logic [8:0] bits);
    for (int i = 8; i >= 0; i--) begin
      o_sda = bits[i];
      #12;
      o_scl = 1'b1;
      #24;
      o_scl = 1'b0;
      #12;
    end
  endtask
  task automatic stop();
    o_sda = 1'b0;
    #12;
    o_scl = 1'b1;
    #24;
    o_sda = 1'b1;
    #24;
  endtask
endmodule

// ==== verification/tb_top.sv ====
`timescale 1ns/10ps
module tb_top;
  import isb_pkg::*;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  isb_bus_s bus = '0;
  isb_eng_s eng = '0;
  isb_pins_s pins;
  logic scl, sda, irq, tx_full, auto_stop, swrst;
  int stop_cnt = 0;
  logic [15:0] rdata;
  logic [7:0] tx_byte;
  logic [1:0] astp;
  int error_cnt = 0;
  int total_checks = 0;

  always #2.5 i_clk = ~i_clk;
  assign pins = '{scl: scl, sda: sda};
  // The stop request is a one-cycle pulse, so count the pulses
  always @(posedge i_clk) if (auto_stop) stop_cnt <= stop_cnt + 1;

  isb_core u_dut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_bus(bus), .o_rdata(rdata), .i_pins(pins),
    .i_eng(eng), .o_tx_byte(tx_byte), .o_tx_full(tx_full), .o_auto_stop(auto_stop),
    .o_soft_reset_hold(swrst), .o_auto_stop_select(astp), .o_irq(irq));
  isb_i2c_model u_bus (.o_scl(scl), .o_sda(sda));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_clk);
    bus.addr <= a;
    bus.wdata <= d;
    bus.wr <= 1'b1;
    @(posedge i_clk);
    bus.wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    bus.addr <= a;
    bus.rd <= 1'b1;
    @(posedge i_clk);
    bus.rd <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask
  // Pulses last one cycle; the clock-hold level is kept
  task automatic eng_pulse(input isb_eng_s e);
    @(posedge i_clk);
    eng <= e;
    @(posedge i_clk);
    eng <= isb_eng_s'(e & 12'h001);
  endtask
  task automatic chk_irq(input logic exp);
    @(posedge i_clk);
    #1;
    chk({15'h0000, irq}, {15'h0000, exp});
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_reset();
    rd_chk(ISB_OFS_STATUS, ISB_RST_WORD);
    rd_chk(ISB_OFS_LIMIT, ISB_RST_WORD);
    rd_chk(ISB_OFS_RXBUF, ISB_RST_WORD);
    rd_chk(ISB_OFS_TXBUF, ISB_RST_WORD);
    rd_chk(16'h01E0, 16'h0000);
    chk_irq(1'b0);
  endtask
  task automatic t_limit();
    wr(ISB_OFS_CTRL, 16'h0005);
    wr(ISB_OFS_LIMIT, 16'h0002);
    wr(ISB_OFS_CTRL, 16'h0004);
    wr(ISB_OFS_LIMIT, 16'h0007);
    rd_chk(ISB_OFS_LIMIT, 16'h0002);
    chk({14'h0000, astp}, {14'h0000, ISB_ASTP_STOP});
  endtask
  task automatic t_rx();
    wr(ISB_OFS_IRQ_MASK, 16'h000F);
    eng_pulse('{rx_done: 1'b1, rx_byte: 8'hA5, default: '0});
    chk_irq(1'b1);
    rd_chk(ISB_OFS_RXBUF, 16'h00A5);
    rd_chk(ISB_OFS_IRQ_STAT, 16'h0000);
    chk_irq(1'b0);
  endtask
  task automatic t_tx();
    wr(ISB_OFS_TXBUF, 16'h005C);
    #1;
    chk({7'h00, tx_full, tx_byte}, 16'h015C);
    eng_pulse('{tx_load: 1'b1, default: '0});
    #1;
    chk({15'h0000, tx_full}, 16'h0000);
    wr(ISB_OFS_TXBUF, 16'h0033);
    rd_chk(ISB_OFS_IRQ_STAT, 16'h0000);
  endtask
  task automatic t_link();
    u_bus.start();
    eng_pulse('{gc_match: 1'b1, scl_hold: 1'b1, default: '0});
    rd_chk(ISB_OFS_STATUS, 16'h0070);
    u_bus.send_byte(9'h0A0);
    u_bus.send_byte(9'h0A5);
    u_bus.send_byte(9'h03C);
    repeat (4) @(posedge i_clk);
    rd_chk(ISB_OFS_STATUS, 16'h0270);
    chk(16'(stop_cnt), 16'h0001);
    rd_chk(ISB_OFS_IRQ_STAT, 16'h0008);
    u_bus.start();
    repeat (4) @(posedge i_clk);
    rd_chk(ISB_OFS_STATUS, 16'h0050);
    u_bus.stop();
    @(posedge i_clk);
    eng.scl_hold <= 1'b0;
    repeat (4) @(posedge i_clk);
    rd_chk(ISB_OFS_STATUS, 16'h0000);
  endtask
  task automatic t_irq();
    wr(ISB_OFS_IRQ_MASK, 16'h0003);
    chk_irq(1'b0);
    wr(ISB_OFS_IRQ_MASK, 16'h0008);
    chk_irq(1'b1);
    wr(ISB_OFS_IRQ_STAT, 16'h000C);
    chk_irq(1'b0);
    rd_chk(ISB_OFS_IRQ_STAT, 16'h0000);
  endtask
  // Flag-only selection with a threshold of one: the address byte must not trip it
  task automatic t_flag();
    wr(ISB_OFS_CTRL, 16'h0001);
    wr(ISB_OFS_CTRL, 16'h0003);
    wr(ISB_OFS_LIMIT, 16'h0001);
    wr(ISB_OFS_CTRL, 16'h0002);
    wr(ISB_OFS_IRQ_STAT, 16'h000F);
    rd_chk(ISB_OFS_LIMIT, 16'h0001);
    chk({14'h0000, astp}, {14'h0000, ISB_ASTP_FLAG});
    u_bus.start();
    u_bus.send_byte(9'h0A0);
    repeat (4) @(posedge i_clk);
    rd_chk(ISB_OFS_IRQ_STAT, 16'h0000);
    u_bus.send_byte(9'h0A5);
    repeat (4) @(posedge i_clk);
    rd_chk(ISB_OFS_STATUS, 16'h0110);
    rd_chk(ISB_OFS_IRQ_STAT, 16'h0008);
    chk(16'(stop_cnt), 16'h0001);
    u_bus.stop();
    repeat (4) @(posedge i_clk);
    rd_chk(ISB_OFS_IRQ_STAT, 16'h000C);
  endtask

  initial begin
    repeat (10) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    t_reset();
    t_limit();
    t_rx();
    t_tx();
    t_link();
    t_irq();
    t_flag();
    results();
  end
  // Whole run needs a few microseconds
  initial begin
    #100000;
    error_cnt++;
    results();
  end
endmodule
